// [shared/tlic_pkg.sv]
// constants and state types shared by the two-level interrupt controller
// assumes a single 125 MHz clock domain and a word-wide AHB-Lite register port
package tlic_pkg;
  localparam int unsigned TLIC_NSRC = 14;
  localparam int unsigned TLIC_IW = 4;
  // register byte offsets
  localparam logic [7:0] TLIC_OFS_ENABLE = 8'h00;
  localparam logic [7:0] TLIC_OFS_GLOBAL = 8'h04;
  localparam logic [7:0] TLIC_OFS_PRIO = 8'h08;
  localparam logic [7:0] TLIC_OFS_PEND = 8'h0C;
  localparam logic [7:0] TLIC_OFS_STATUS = 8'h10;
  // field positions in the status word
  localparam int unsigned TLIC_ST_INS_LO = 0;
  localparam int unsigned TLIC_ST_INS_HI = 1;
  localparam int unsigned TLIC_ST_HOLD = 2;
  localparam int unsigned TLIC_ST_REQ = 3;
  localparam int unsigned TLIC_ST_LVL = 4;
  localparam int unsigned TLIC_ST_IDX = 8;
  // values after reset
  localparam logic [13:0] TLIC_RST_ENABLE = 14'h0000;
  localparam logic [13:0] TLIC_RST_PRIO = 14'h0000;
  localparam logic [13:0] TLIC_RST_PEND = 14'h0000;
  // flags that clear themselves when the core vectors
  localparam logic [13:0] TLIC_AUTO_CLR = 14'h000F;
  // vector of source i is base plus i times step
  localparam logic [15:0] TLIC_VEC_BASE = 16'h0003;
  localparam logic [15:0] TLIC_VEC_STEP = 16'h0008;
  localparam logic [1:0] TLIC_HTRANS_NONSEQ = 2'h2;
  // per-cycle state of the top module
  typedef struct packed {
    logic [13:0] en;
    logic gen;
    logic [13:0] prio;
    logic [13:0] pend;
    logic ins_lo;
    logic ins_hi;
    logic hold;
    logic req;
    logic lvl;
    logic [3:0] idx;
    logic [15:0] vec;
    logic ap_wr;
    logic [7:0] ap_addr;
    logic [31:0] rdata;
    logic ready;
  } tlic_state_t;
endpackage

// [shared/tlic_arb_if.sv]
// carrier between the controller core and its priority arbiter
// assumes both ends sit in the same clock domain; no timing inside
`timescale 1ns/1ps
`default_nettype none
interface tlic_arb_if;
  logic [13:0] cand;
  logic [13:0] prio;
  logic allow_hi;
  logic allow_lo;
  logic valid;
  logic level;
  logic [3:0] idx;
  modport ctrl (output cand, output prio, output allow_hi, output allow_lo,
    input valid, input level, input idx);
  modport arb (input cand, input prio, input allow_hi, input allow_lo,
    output valid, output level, output idx);
endinterface
`default_nettype wire

// [rtl/tlic_arbiter.sv]
// two-level fixed-order priority arbiter for the interrupt controller
// assumes candidates are already gated by enables; purely combinational
`timescale 1ns/1ps
`default_nettype none
module tlic_arbiter
  import tlic_pkg::*;
(
  tlic_arb_if.arb port
);
  logic [13:0] hi_set;
  logic [13:0] lo_set;
  logic [13:0] pick;

  // high level first, then the lower index inside a level
  always_comb
  begin
    hi_set = port.cand & port.prio & {14{port.allow_hi}};
    lo_set = port.cand & ~port.prio & {14{port.allow_lo}};
    pick = (|hi_set) ? hi_set : lo_set;
    port.valid = |pick;
    port.level = |hi_set;
    port.idx = 4'h0;
    // walk down so the lowest set index wins the tie
    for (int i = TLIC_NSRC - 1; i >= 0; i--)
    begin
      if (pick[i])
      begin
        port.idx = TLIC_IW'(i);
      end
    end
  end
endmodule // tlic_arbiter
`default_nettype wire

// [rtl/tlic_top.sv]
// two-level interrupt controller: pending flags, enables, arbitration,
// vector call request and nesting record for an 8-bit core.
// assumes an AHB-Lite master on one clock and a core sequencer that
// pulses instr_done, return_from_interrupt and call_ack synchronously to the clock.
//
// Functional notes
// - fourteen sources, each assignable to low or high priority
// - a source event sets its pending flag
// - enabled pending flag raises a call request with its fixed vector
// - routines end with return; core resumes the interrupted flow
// - flags set even when disabled; disabled flags never request
// - per-source enables count only while the global enable is one
// - global enable zero blocks every source
// - request seen one cycle late, so single-cycle follower may take it
// - some flags clear on vectoring; software clears the rest
// - flag still set after return requests again after one instruction
// - software writing a flag to one acts like a hardware set
// - high preempts running low; nothing preempts running high
// - one priority bit per source, reset to low
// - high level wins, fixed order breaks ties within a level
// - requests sampled and decoded every cycle
// - equal or lower requests wait for return and one instruction
// - at least one instruction runs after return before the next call
//
// The register offsets and the AHB-Lite slave port are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
module tlic_top
  import tlic_pkg::*;
(
  input wire logic core_clk_in,
  input wire logic nrst_in,
  input wire logic hsel_in,
  input wire logic [31:0] haddr_in,
  input wire logic [1:0] htrans_in,
  input wire logic hwrite_in,
  input wire logic [2:0] hsize_in,
  input wire logic [31:0] hwdata_in,
  input wire logic hready_in,
  output logic hreadyout_out,
  output logic hresp_out,
  output logic [31:0] hrdata_out,
  input wire logic [13:0] irq_src_in,
  input wire logic instr_done_in,
  input wire logic return_from_interrupt_in,
  input wire logic call_ack_in,
  output logic call_req_out,
  output logic call_level_out,
  output logic [15:0] call_vec_out
);
  logic [1:0] rst_sync;
  logic rst_n;
  tlic_state_t st;
  tlic_state_t next_st;
  logic ap_take;
  logic wr_now;
  logic [13:0] next_pend;
  logic [13:0] vec_clr;
  logic [31:0] rd_word;

  tlic_arb_if arb ();

  tlic_arbiter u_arb (
    .port(arb)
  );

  // reset released through two flops so every state flop leaves reset together
  always_ff @(posedge core_clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      rst_sync <= 2'h0;
    else
      rst_sync <= {rst_sync[0], 1'b1};
  end
  assign rst_n = rst_sync[1];

  // candidates: flag set, own enable on, and global enable on
  assign arb.cand = st.pend & st.en & {14{st.gen}};
  assign arb.prio = st.prio;
  // high may enter while only low runs; low only when idle
  assign arb.allow_hi = !st.ins_hi;
  assign arb.allow_lo = !st.ins_hi && !st.ins_lo;

  // address phase of a bus transfer is taken every cycle hsel, hready and htrans[1] are all high
  assign ap_take = hsel_in && hready_in && htrans_in[1];
  assign wr_now = st.ap_wr;

  // read mux sampled in the address phase, returned in the data phase
  always_comb
  begin
    rd_word = 32'h0000_0000;
    unique case (haddr_in[7:0])
      TLIC_OFS_ENABLE: rd_word = {18'h00000, st.en};
      TLIC_OFS_GLOBAL: rd_word = {31'h0000_0000, st.gen};
      TLIC_OFS_PRIO: rd_word = {18'h00000, st.prio};
      TLIC_OFS_PEND: rd_word = {18'h00000, st.pend};
      TLIC_OFS_STATUS:
      begin
        rd_word[TLIC_ST_INS_LO] = st.ins_lo;
        rd_word[TLIC_ST_INS_HI] = st.ins_hi;
        rd_word[TLIC_ST_HOLD] = st.hold;
        rd_word[TLIC_ST_REQ] = st.req;
        rd_word[TLIC_ST_LVL] = st.lvl;
        rd_word[TLIC_ST_IDX +: TLIC_IW] = st.idx;
      end
      default: rd_word = 32'h0000_0000; // unmapped reads as zero
    endcase
  end

  // flags cleared by the core taking the call, for self-clearing sources only
  always_comb
  begin
    vec_clr = 14'h0000;
    if (call_ack_in && st.req)
      vec_clr[st.idx] = TLIC_AUTO_CLR[st.idx];
  end

  // pending flags: software write, vector clear, then hardware set wins
  always_comb
  begin
    next_pend = st.pend;
    if (wr_now && st.ap_addr == TLIC_OFS_PEND)
      next_pend = hwdata_in[13:0];
    next_pend = (next_pend & ~vec_clr) | irq_src_in;
  end

  // next state of the whole block
  always_comb
  begin
    next_st = st;
    next_st.ready = 1'b1;
    next_st.pend = next_pend;
    // register writes land in the data phase
    if (wr_now)
    begin
      unique case (st.ap_addr)
        TLIC_OFS_ENABLE: next_st.en = hwdata_in[13:0];
        TLIC_OFS_GLOBAL: next_st.gen = hwdata_in[0];
        TLIC_OFS_PRIO: next_st.prio = hwdata_in[13:0];
        default: next_st.ap_wr = 1'b0;
      endcase
    end
    next_st.ap_wr = ap_take && hwrite_in;
    next_st.ap_addr = haddr_in[7:0];
    if (ap_take && !hwrite_in)
      next_st.rdata = rd_word;
    // nesting record: core took the call, mark its level busy
    if (call_ack_in && st.req)
    begin
      if (st.lvl)
        next_st.ins_hi = 1'b1;
      else
        next_st.ins_lo = 1'b1;
    end
    // return releases the most recent level, high first
    if (return_from_interrupt_in)
    begin
      if (st.ins_hi)
        next_st.ins_hi = 1'b0;
      else
        next_st.ins_lo = 1'b0;
    end
    // after a return one instruction must complete before a new call
    if (return_from_interrupt_in)
      next_st.hold = 1'b1;
    else if (instr_done_in)
      next_st.hold = 1'b0;
    // request decoded every cycle; the flop adds one detect cycle
    next_st.req = arb.valid && !call_ack_in && !return_from_interrupt_in
      && !(st.hold && !instr_done_in);
    next_st.lvl = arb.level;
    next_st.idx = arb.idx;
    next_st.vec = TLIC_VEC_BASE + {9'h000, arb.idx, 3'h0};
  end

  // single state register; all control clears at reset
  always_ff @(posedge core_clk_in or negedge rst_n)
  begin
    if (!rst_n)
    begin
      st <= '0;
      st.en <= TLIC_RST_ENABLE;
      st.prio <= TLIC_RST_PRIO;
      st.pend <= TLIC_RST_PEND;
    end
    else
      st <= next_st;
  end

  // outputs straight from the state flops; hresp tied to okay
  assign hreadyout_out = st.ready;
  assign hresp_out = 1'b0;
  assign hrdata_out = st.rdata;
  assign call_req_out = st.req;
  assign call_level_out = st.lvl;
  assign call_vec_out = st.vec;

  // a source pulse is held in its flag on the next edge
  chk_pend_hw_set: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (|irq_src_in) |=> ((st.pend & $past(irq_src_in)) == $past(irq_src_in)))
    else $error("source event did not set its pending flag");

  // software write of one to a flag keeps it set
  chk_pend_sw_set: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (st.ap_wr && st.ap_addr == TLIC_OFS_PEND && hwdata_in[13:0] != 14'h0000)
    |=> ((st.pend & $past(hwdata_in[13:0])) == $past(hwdata_in[13:0])))
    else $error("software-set pending flag was lost");

  // no request without an enabled flag under a global enable
  chk_req_cause: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    $rose(call_req_out) |-> $past(st.gen) && ($past(st.pend & st.en) != 14'h0000))
    else $error("request raised without an enabled pending flag");

  // global enable off blocks the following request slot
  chk_global_block: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    !st.gen |=> !call_req_out)
    else $error("request raised while global enable was off");

  // high routine running: nothing gets through
  chk_hi_no_preempt: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    st.ins_hi |=> !call_req_out)
    else $error("request raised during a high-level routine");

  // low request waits while any routine runs
  chk_low_waits: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (st.ins_lo || st.ins_hi) |=> !(call_req_out && !call_level_out))
    else $error("low request raised during a running routine");

  // return then one instruction before the next request can show
  chk_return_from_interrupt_gap: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    return_from_interrupt_in |=> !call_req_out ##1 (!call_req_out || $past(instr_done_in)))
    else $error("request raised before the instruction after return");

  // taking a high call marks the high level busy
  chk_nest_level: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (call_ack_in && call_req_out && call_level_out && !return_from_interrupt_in) |=> st.ins_hi)
    else $error("high in-service level not marked when the call was taken");

  // return while a high routine runs frees the high level
  chk_nest_release: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (return_from_interrupt_in && st.ins_hi) |=> !st.ins_hi)
    else $error("high in-service level not released by the return");

  // vector matches the winning source a cycle after the decode
  chk_vec_index: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    call_req_out |-> call_vec_out == TLIC_VEC_BASE + TLIC_VEC_STEP * {12'h000, st.idx})
    else $error("vector does not match the winning source");

  // high level candidate always beats a low one
  chk_hi_first: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (!st.ins_hi && (st.pend & st.en & st.prio) != 14'h0000 && st.gen)
    |=> call_level_out)
    else $error("low level chosen over an eligible high request");

  // bus always answers ready and okay
  chk_ahb_okay: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    $past(rst_n) |-> (hreadyout_out && !hresp_out))
    else $error("bus answer not ready okay");

  // a self-clearing flag drops on the edge the core takes its call
  chk_pend_auto_clr: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (call_ack_in && st.req && TLIC_AUTO_CLR[st.idx] && !irq_src_in[st.idx]
    && !(st.ap_wr && st.ap_addr == TLIC_OFS_PEND)) |=> !st.pend[$past(st.idx)])
    else $error("self-clearing flag still set after the call");

  // other flags survive the call until software clears them
  chk_pend_sticky: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (call_ack_in && st.req && st.pend[st.idx] && !TLIC_AUTO_CLR[st.idx]
    && !(st.ap_wr && st.ap_addr == TLIC_OFS_PEND)) |=> st.pend[$past(st.idx)])
    else $error("software-cleared flag dropped by the call");

  // global enable word lands in the data phase
  chk_gen_write: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (st.ap_wr && st.ap_addr == TLIC_OFS_GLOBAL) |=> (st.gen == $past(hwdata_in[0])))
    else $error("global enable write did not land");

  // per-source enable word lands in the data phase
  chk_en_write: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (st.ap_wr && st.ap_addr == TLIC_OFS_ENABLE) |=> (st.en == $past(hwdata_in[13:0])))
    else $error("source enable write did not land");

  // priority word lands in the data phase
  chk_prio_write: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (st.ap_wr && st.ap_addr == TLIC_OFS_PRIO) |=> (st.prio == $past(hwdata_in[13:0])))
    else $error("priority write did not land");

  // the cycle after the core takes a call shows no request
  chk_ack_gap: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    call_ack_in |=> !call_req_out)
    else $error("request still shown right after the call was taken");

  // a flag without its own enable never reaches the core
  chk_disabled_quiet: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    ((st.pend & st.en) == 14'h0000) |=> !call_req_out)
    else $error("request raised with no enabled pending flag");

  // one detect cycle: an eligible winner shows on the next edge
  chk_detect_cycle: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (arb.valid && !call_ack_in && !return_from_interrupt_in && !st.hold) |=> call_req_out)
    else $error("eligible winner not requested after one detect cycle");

  // return arms the one-instruction hold
  chk_return_from_interrupt_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    return_from_interrupt_in |=> st.hold)
    else $error("return did not arm the hold");

  // a finished instruction lifts the hold
  chk_hold_clear: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (st.hold && instr_done_in && !return_from_interrupt_in) |=> !st.hold)
    else $error("hold not lifted by the instruction after return");

  // taking a low call marks the low level busy
  chk_lo_mark: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (call_ack_in && call_req_out && !call_level_out && !return_from_interrupt_in) |=> st.ins_lo)
    else $error("low in-service level not marked when the call was taken");

  // return with only a low routine running frees the low level
  chk_lo_release: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    (return_from_interrupt_in && !st.ins_hi && st.ins_lo) |=> !st.ins_lo)
    else $error("low in-service level not released by the return");

  // the winner index always names one of the fourteen sources
  chk_idx_range: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    call_req_out |-> (st.idx < TLIC_IW'(TLIC_NSRC)))
    else $error("winner index outside the source range");

  // the level shown is the winner's own priority bit at decode time
  chk_level_bit: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    call_req_out |-> (call_level_out == $past(st.prio[arb.idx])))
    else $error("request level differs from the winner priority bit");

  // read data stand until the next read address phase is taken
  chk_rdata_hold: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    !(hsel_in && hready_in && htrans_in[1] && !hwrite_in) |=> $stable(hrdata_out))
    else $error("read data changed without a read");

  // leaving reset: enables, priorities, nesting and request all clear
  chk_reset_state: assert property (@(posedge core_clk_in) disable iff (!rst_n)
    $rose(rst_n) |-> (st.en == TLIC_RST_ENABLE && !st.gen && st.prio == TLIC_RST_PRIO
    && !st.ins_lo && !st.ins_hi && !st.hold && !call_req_out))
    else $error("control state not clear when reset was released");
endmodule // tlic_top
`default_nettype wire

// [bench/tlic_core_model.sv]
// core sequencer model: one instruction ends every other cycle
// assumes the bench pulses return_from_interrupt_cmd_in for one cycle per return
`timescale 1ns/1ps
`default_nettype none
module tlic_core_model
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic call_req_in,
  input wire logic call_level_in,
  input wire logic [15:0] call_vec_in,
  input wire logic return_from_interrupt_cmd_in,
  output logic instr_done_out,
  output logic return_from_interrupt_out,
  output logic call_ack_out,
  output logic [7:0] n_ack_out,
  output logic [15:0] vec_seen_out,
  output logic lvl_seen_out
);
  logic take;
  // a request is taken only at an instruction boundary, never two acks in a row
  assign take = call_req_in && instr_done_out && !call_ack_out;
  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
    begin
      instr_done_out <= 1'b0;
      return_from_interrupt_out <= 1'b0;
      call_ack_out <= 1'b0;
      n_ack_out <= 8'h00;
      vec_seen_out <= 16'h0000;
      lvl_seen_out <= 1'b0;
    end
    else
    begin
      instr_done_out <= ~instr_done_out;
      return_from_interrupt_out <= return_from_interrupt_cmd_in;
      call_ack_out <= take;
      if (take)
      begin
        n_ack_out <= n_ack_out + 8'h01;
        vec_seen_out <= call_vec_in;
        lvl_seen_out <= call_level_in;
      end
    end
  end
endmodule // tlic_core_model
`default_nettype wire

// [bench/two_level_interrupt_controller_bench.sv]
// self-checking bench: AHB-Lite master, event pulses, core model
// assumes the controller answers bus transfers with zero wait states
`timescale 1ns/1ps
`default_nettype none
module two_level_interrupt_controller_bench;
  import tlic_pkg::*;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic hsel = 1'b0;
  logic [31:0] haddr = 32'h0;
  logic [1:0] htrans = 2'h0;
  logic hwrite = 1'b0;
  logic [31:0] hwdata = 32'h0;
  logic [13:0] irq = 14'h0;
  logic return_from_interrupt_cmd = 1'b0;
  logic hrdy, hresp, idone, return_from_interrupt, ack, creq, clvl, lseen;
  logic [31:0] hrdata, r;
  logic [15:0] cvec, vseen;
  logic [7:0] n_ack, seen;
  logic [13:0] p;
  int seed = 32'h9e47;
  int n_mismatch = 0;
  int tests_run = 0;
  int idx;
  tlic_top DUT (.core_clk_in(clk), .nrst_in(nrst), .hsel_in(hsel),
    .haddr_in(haddr), .htrans_in(htrans), .hwrite_in(hwrite), .hsize_in(3'h2),
    .hwdata_in(hwdata), .hready_in(hrdy), .hreadyout_out(hrdy),
    .hresp_out(hresp), .hrdata_out(hrdata), .irq_src_in(irq),
    .instr_done_in(idone), .return_from_interrupt_in(return_from_interrupt), .call_ack_in(ack),
    .call_req_out(creq), .call_level_out(clvl), .call_vec_out(cvec));
  tlic_core_model core (.clk_in(clk), .nrst_in(nrst), .call_req_in(creq),
    .call_level_in(clvl), .call_vec_in(cvec), .return_from_interrupt_cmd_in(return_from_interrupt_cmd),
    .instr_done_out(idone), .return_from_interrupt_out(return_from_interrupt), .call_ack_out(ack),
    .n_ack_out(n_ack), .vec_seen_out(vseen), .lvl_seen_out(lseen));
  always #4 clk = ~clk;
  task summarize;
    $display("mismatches %0d, checks %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask
  task chk(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp)
    begin
      $display("CHECK FAILED t=%0t got %h exp %h", $time, got, exp);
      n_mismatch++;
    end
  endtask
  task hang;
    n_mismatch++;
    $display("CHECK FAILED t=%0t wait ran out", $time);
    summarize();
  endtask
  // release reset on an edge, then wait for the bus to come up
  task release_rst;
    @(posedge clk);
    nrst <= 1'b1;
    for (idx = 0; idx < 20 && hrdy !== 1'b1; idx++) @(posedge clk);
    if (idx == 20) hang();
  endtask
  // address phase held until hready, then data phase held until hready
  task bus(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge clk);
    hsel <= 1'b1;
    haddr <= {24'h0, a};
    hwrite <= w;
    htrans <= TLIC_HTRANS_NONSEQ;
    do @(posedge clk); while (hrdy !== 1'b1 && ++k < 50);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clk); while (hrdy !== 1'b1 && ++k < 99);
    r = hrdata;
    chk({31'h0, hresp}, 32'h0);
    if (k >= 99) hang();
  endtask
  task pulse(input logic [13:0] m);
    @(posedge clk);
    irq <= m;
    @(posedge clk);
    irq <= 14'h0;
  endtask
  task return_from_interrupt_p;
    @(posedge clk);
    return_from_interrupt_cmd <= 1'b1;
    @(posedge clk);
    return_from_interrupt_cmd <= 1'b0;
    repeat (3) @(posedge clk);
  endtask
  // waits for the core to take a call, then compares vector and level
  task wait_ack(input logic [15:0] v, input logic l);
    int k;
    for (k = 0; k < 100 && n_ack === seen; k++) @(posedge clk);
    if (k == 100) hang();
    seen = n_ack;
    chk({16'h0, vseen}, {16'h0, v});
    chk({31'h0, lseen}, {31'h0, l});
  endtask
  function automatic logic [15:0] vec_of(input int i);
    return TLIC_VEC_BASE + 16'(i * 8);
  endfunction
  initial
  begin
    seen = 8'h00;
    repeat (7) @(posedge clk);
    release_rst();
    // reset values of enable, global, priority, pending and status words
    for (idx = 0; idx < 5; idx++)
    begin
      bus(1'b0, 8'(idx * 4), 32'h0);
      chk(r, 32'h0);
    end
    pulse(14'h0020);
    bus(1'b0, TLIC_OFS_PEND, 32'h0);
    chk(r, 32'h20);
    bus(1'b1, TLIC_OFS_ENABLE, 32'h3FFF);
    repeat (6) @(posedge clk);
    chk({31'h0, creq}, 32'h0);
    bus(1'b1, TLIC_OFS_GLOBAL, 32'h1);
    wait_ack(vec_of(5), 1'b0);
    bus(1'b1, TLIC_OFS_PEND, 32'h0);
    return_from_interrupt_p();
    // low routine preempted by high; high never preempted
    bus(1'b1, TLIC_OFS_PEND, 32'h10);
    wait_ack(vec_of(4), 1'b0);
    bus(1'b1, TLIC_OFS_PRIO, 32'hC0);
    pulse(14'h0040);
    wait_ack(vec_of(6), 1'b1);
    bus(1'b0, TLIC_OFS_STATUS, 32'h0);
    chk(r, 32'h0000_0003);
    pulse(14'h0080);
    repeat (20) @(posedge clk);
    chk({24'h0, n_ack}, {24'h0, seen});
    bus(1'b1, TLIC_OFS_PEND, 32'h90);
    return_from_interrupt_p();
    wait_ack(vec_of(7), 1'b1);
    bus(1'b1, TLIC_OFS_PEND, 32'h10);
    return_from_interrupt_p();
    repeat (10) @(posedge clk);
    chk({24'h0, n_ack}, {24'h0, seen});
    return_from_interrupt_p();
    wait_ack(vec_of(4), 1'b0);
    bus(1'b1, TLIC_OFS_PEND, 32'h0);
    return_from_interrupt_p();
    // two low flags written together: fixed order wins
    bus(1'b1, TLIC_OFS_PRIO, 32'h0);
    bus(1'b1, TLIC_OFS_PEND, 32'h1200);
    wait_ack(vec_of(9), 1'b0);
    bus(1'b1, TLIC_OFS_PEND, 32'h0);
    return_from_interrupt_p();
    pulse(14'h0001);
    wait_ack(vec_of(0), 1'b0);
    bus(1'b0, TLIC_OFS_PEND, 32'h0);
    chk(r, 32'h0);
    return_from_interrupt_p();
    // enable clear followed by a second clear, as software must do
    bus(1'b1, TLIC_OFS_GLOBAL, 32'h0);
    bus(1'b1, TLIC_OFS_GLOBAL, 32'h0);
    pulse(14'h0002);
    repeat (10) @(posedge clk);
    chk({24'h0, n_ack}, {24'h0, seen});
    bus(1'b0, TLIC_OFS_PEND, 32'h0);
    chk(r, 32'h2);
    bus(1'b1, TLIC_OFS_GLOBAL, 32'h1);
    wait_ack(vec_of(1), 1'b0);
    return_from_interrupt_p();
    // random sources and levels, last index first
    p = 14'($random(seed));
    bus(1'b1, TLIC_OFS_PRIO, {18'h0, p});
    for (int k = 0; k < 6; k++)
    begin
      idx = (k == 0) ? 13 : {$random(seed)} % 14;
      pulse(14'h1 << idx);
      wait_ack(vec_of(idx), p[idx]);
      bus(1'b1, TLIC_OFS_PEND, 32'h0);
      return_from_interrupt_p();
    end
    // reset in mid-routine clears enables, flags and the nesting record
    bus(1'b1, TLIC_OFS_PEND, 32'h10);
    wait_ack(vec_of(4), p[4]);
    nrst <= 1'b0;
    repeat (2) @(posedge clk);
    release_rst();
    seen = 8'h00;
    for (idx = 0; idx < 5; idx++)
    begin
      bus(1'b0, 8'(idx * 4), 32'h0);
      chk(r, 32'h0);
    end
    summarize();
  end
endmodule // two_level_interrupt_controller_bench
`default_nettype wire
